// >>> verilog/perf_monitor_defs.svh
// Purpose: offsets, field positions, reset values and timing for the counter map
// Assumes: indirect offsets are byte indexes on a 7-bit indirect address
// Notes: definitions only
`ifndef PERF_MONITOR_DEFS_SVH
`define PERF_MONITOR_DEFS_SVH

`define FRAME_ALIGN_CHANGE_OFS      7'h04
`define OUT_OF_FRAME_OFS            7'h05
`define PATTERN_ERROR_LOW_OFS       7'h06
`define PATTERN_ERROR_HIGH_OFS      7'h07
`define LINE_VIOLATION_LOW_OFS      7'h08
`define LINE_VIOLATION_HIGH_OFS     7'h09
`define NATIONAL_CRC_LOW_OFS        7'h0A
`define NATIONAL_CRC_HIGH_OFS       7'h0B
`define FAR_BLOCK_LOW_OFS           7'h0C
`define FAR_BLOCK_HIGH_OFS          7'h0D
`define NATIONAL_FAR_BLOCK_LOW_OFS  7'h0E
`define NATIONAL_FAR_BLOCK_HIGH_OFS 7'h0F

// upper two bits of a 10-bit count sit at bits 5:4 of the high byte
`define TEN_BIT_HIGH_LSB            4
`define REG_RESET_VALUE             8'h00
`define UNMAPPED_READ_VALUE         8'h00

`define SNAPSHOT_PERIOD_NS          1000000000
`define CLK_PERIOD_NS               5
`define SNAPSHOT_PERIOD_CYCLES      (`SNAPSHOT_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// >>> verilog/perf_monitor_pkg.sv
// Purpose: types shared by the performance monitor counter map
// Assumes: nothing beyond the defs header
// Notes: counts_t field widths follow the mapped counter widths
package perf_monitor_pkg;

    typedef struct packed {
        logic       frame_align_change;
        logic       out_of_frame;
        logic       pattern_error;
        logic       bipolar_violation;
        logic       code_violation;
        logic       national_crc_error;
        logic       far_block_error;
        logic       national_far_block;
    } event_pulses_t;

    typedef struct packed {
        logic [2:0]  frame_align_change_count;
        logic [4:0]  out_of_frame_count;
        logic [15:0] pattern_error_count;
        logic [15:0] line_violation_count;
        logic [9:0]  national_crc_error_count;
        logic [9:0]  far_block_error_count;
        logic [9:0]  national_far_block_count;
    } counts_t;

    typedef struct packed {
        logic [6:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } ind_req_t;

endpackage

// >>> verilog/performance_monitor.sv
// Purpose: performance monitor counter map, indirect offsets 04h to 0Fh
// Assumes: event pulses are one clk wide and synchronous to clk
// Notes: live counters run freely; the map shows the last snapshot
// How it works
// - offset 04h shows 3-bit frame-alignment-change count
// - offset 05h shows 5-bit out-of-frame count
// - 16-bit pattern error count at 06h/07h
// - line count: bipolar (AMI) or code violations (HDB3)
// - 10-bit national CRC count at 0Ah/0Bh
// - 10-bit far-end block count at 0Ch/0Dh
// - 10-bit national far-end block count 0Eh/0Fh
// - count LSB at bit 0 of low byte
// - ten-bit counts: bits 9:8 at 5:4, rest reserved
// - trigger rising edge refreshes whole map together
// - auto enable refreshes map once per second
`timescale 1ns/1ps
`include "perf_monitor_defs.svh"

module performance_monitor #(
    parameter int unsigned SNAPSHOT_PERIOD_CYCLES = `SNAPSHOT_PERIOD_CYCLES
) (
    input  wire logic                          clk,                  // 200 MHz clock
    input  wire logic                          srst,                 // sync reset, high
    input  wire perf_monitor_pkg::event_pulses_t events,             // one-cycle event pulses
    input  wire logic                          hdb3_select,          // 1 HDB3, 0 AMI decoding
    input  wire logic                          snapshot_trigger,     // refresh on 0 to 1
    input  wire logic                          auto_snapshot_enable, // refresh every second
    input  wire perf_monitor_pkg::ind_req_t    ind_req,              // indirect access request
    output logic [7:0]                         ind_rdata,            // read data, registered
    output logic                               ind_ack,              // access done pulse
    output logic                               snapshot_taken        // map refreshed pulse
);

    localparam logic [31:0] PERIOD_LAST = 32'(SNAPSHOT_PERIOD_CYCLES - 1);

    // saturating increment: wrap would make a busy interval look quiet
    function automatic logic [15:0] bump(input logic [15:0] value,
                                         input logic [15:0] max_value,
                                         input logic        hit);
        bump = (hit && value != max_value) ? 16'(value + 16'h0001) : value;
    endfunction

    // restart value at a snapshot keeps an event landing in that cycle
    function automatic logic [15:0] restart(input logic hit);
        restart = hit ? 16'h0001 : 16'h0000;
    endfunction

    function automatic logic [7:0] ten_high(input logic [9:0] count);
        ten_high = {2'b00, count[9:8], 4'h0};
    endfunction

    function automatic logic [7:0] map_byte(input logic [6:0]                addr,
                                            input perf_monitor_pkg::counts_t snap);
        case (addr)
            `FRAME_ALIGN_CHANGE_OFS:      map_byte = {5'h00, snap.frame_align_change_count};
            `OUT_OF_FRAME_OFS:            map_byte = {3'h0, snap.out_of_frame_count};
            `PATTERN_ERROR_LOW_OFS:       map_byte = snap.pattern_error_count[7:0];
            `PATTERN_ERROR_HIGH_OFS:      map_byte = snap.pattern_error_count[15:8];
            `LINE_VIOLATION_LOW_OFS:      map_byte = snap.line_violation_count[7:0];
            `LINE_VIOLATION_HIGH_OFS:     map_byte = snap.line_violation_count[15:8];
            `NATIONAL_CRC_LOW_OFS:        map_byte = snap.national_crc_error_count[7:0];
            `NATIONAL_CRC_HIGH_OFS:       map_byte = ten_high(snap.national_crc_error_count);
            `FAR_BLOCK_LOW_OFS:           map_byte = snap.far_block_error_count[7:0];
            `FAR_BLOCK_HIGH_OFS:          map_byte = ten_high(snap.far_block_error_count);
            `NATIONAL_FAR_BLOCK_LOW_OFS:  map_byte = snap.national_far_block_count[7:0];
            `NATIONAL_FAR_BLOCK_HIGH_OFS: map_byte = ten_high(snap.national_far_block_count);
            default:                      map_byte = `UNMAPPED_READ_VALUE;
        endcase
    endfunction

    // refresh timing state
    logic        trigger_prev;
    logic        next_trigger_prev;
    logic [31:0] period_count;
    logic [31:0] next_period_count;
    logic        trigger_edge;
    logic        period_tick;
    logic        take;
    logic        next_snapshot_taken;

    assign trigger_edge = snapshot_trigger & ~trigger_prev;
    assign period_tick  = auto_snapshot_enable && (period_count == PERIOD_LAST);
    assign take         = trigger_edge | period_tick;

    always_comb begin
        next_trigger_prev   = snapshot_trigger;
        next_snapshot_taken = take;
        if (!auto_snapshot_enable || period_tick) begin
            next_period_count = 32'h0000_0000;
        end else begin
            next_period_count = 32'(period_count + 32'h0000_0001);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            trigger_prev   <= 1'b0;
            period_count   <= 32'h0000_0000;
            snapshot_taken <= 1'b0;
        end else begin
            trigger_prev   <= next_trigger_prev;
            period_count   <= next_period_count;
            snapshot_taken <= next_snapshot_taken;
        end
    end

    // live counters and snapshot
    perf_monitor_pkg::counts_t live;
    perf_monitor_pkg::counts_t next_live;
    perf_monitor_pkg::counts_t snap;
    perf_monitor_pkg::counts_t next_snap;
    logic                      line_hit;

    assign line_hit = hdb3_select ? events.code_violation : events.bipolar_violation;

    always_comb begin
        if (take) begin
            next_live.frame_align_change_count = 3'(restart(events.frame_align_change));
            next_live.out_of_frame_count       = 5'(restart(events.out_of_frame));
            next_live.pattern_error_count      = restart(events.pattern_error);
            next_live.line_violation_count     = restart(line_hit);
            next_live.national_crc_error_count = 10'(restart(events.national_crc_error));
            next_live.far_block_error_count    = 10'(restart(events.far_block_error));
            next_live.national_far_block_count = 10'(restart(events.national_far_block));
        end else begin
            next_live.frame_align_change_count = 3'(bump(
                {13'h0000, live.frame_align_change_count}, 16'h0007,
                events.frame_align_change));
            next_live.out_of_frame_count = 5'(bump(
                {11'h000, live.out_of_frame_count}, 16'h001F, events.out_of_frame));
            next_live.pattern_error_count = bump(
                live.pattern_error_count, 16'hFFFF, events.pattern_error);
            next_live.line_violation_count = bump(
                live.line_violation_count, 16'hFFFF, line_hit);
            next_live.national_crc_error_count = 10'(bump(
                {6'h00, live.national_crc_error_count}, 16'h03FF,
                events.national_crc_error));
            next_live.far_block_error_count = 10'(bump(
                {6'h00, live.far_block_error_count}, 16'h03FF, events.far_block_error));
            next_live.national_far_block_count = 10'(bump(
                {6'h00, live.national_far_block_count}, 16'h03FF,
                events.national_far_block));
        end
        // whole group copied in one cycle
        next_snap = take ? live : snap;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            live <= '0;
            snap <= '0;
        end else begin
            live <= next_live;
            snap <= next_snap;
        end
    end

    // indirect access port
    logic [7:0] next_ind_rdata;
    logic       next_ind_ack;

    always_comb begin
        next_ind_ack   = ind_req.rd | ind_req.wr;
        next_ind_rdata = ind_rdata;
        if (ind_req.rd) begin
            next_ind_rdata = map_byte(ind_req.addr, snap);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ind_rdata <= `REG_RESET_VALUE;
            ind_ack   <= 1'b0;
        end else begin
            ind_rdata <= next_ind_rdata;
            ind_ack   <= next_ind_ack;
        end
    end

endmodule // performance_monitor

// >>> verif/perf_monitor_asserts.sv
// Purpose: port checks of the performance monitor counter map
// Assumes: one clock, sync reset high
// Notes: sees only the top module's ports
`timescale 1ns/1ps
module perf_monitor_checker #(
    parameter int unsigned SNAPSHOT_PERIOD_CYCLES = 20
) (
    input wire logic                            clk,                  // clock
    input wire logic                            srst,                 // sync reset
    input wire perf_monitor_pkg::event_pulses_t events,               // event pulses
    input wire logic                            hdb3_select,          // decode select
    input wire logic                            snapshot_trigger,     // refresh trigger
    input wire logic                            auto_snapshot_enable, // auto refresh
    input wire perf_monitor_pkg::ind_req_t      ind_req,              // request
    input wire logic [7:0]                      ind_rdata,            // read data
    input wire logic                            ind_ack,              // access done
    input wire logic                            snapshot_taken        // refresh pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // cycles since the last refresh while auto refresh stays on
    int unsigned since_snapshot;
    always_ff @(posedge clk) begin
        if (srst || !auto_snapshot_enable) begin
            since_snapshot <= 32'h0000_0000;
        end else if (snapshot_taken) begin
            since_snapshot <= 32'h0000_0001;
        end else begin
            since_snapshot <= since_snapshot + 32'h0000_0001;
        end
    end
    a_auto_period: assert property (since_snapshot <= SNAPSHOT_PERIOD_CYCLES)
        else $error("auto refresh late");
    a_ack_after_req: assert property ((ind_req.rd || ind_req.wr) |=> ind_ack)
        else $error("no ack after request");
    a_rdata_holds: assert property (!ind_req.rd |=> $stable(ind_rdata))
        else $error("read data moved without read");
    a_trigger_refresh: assert property ($rose(snapshot_trigger) |=> snapshot_taken)
        else $error("trigger edge gave no refresh");
    // reset release may count a high trigger as an edge
    a_refresh_cause: assert property (snapshot_taken |-> $past(auto_snapshot_enable)
        || $past(srst, 2) || ($past(snapshot_trigger) && !$past(snapshot_trigger, 2)))
        else $error("refresh without cause");
    a_reserved_zero: assert property (ind_ack && $past(ind_req.rd)
        && ($past(ind_req.addr) inside {7'h0B, 7'h0D, 7'h0F})
        |-> ind_rdata[7:6] == 2'h0 && ind_rdata[3:0] == 4'h0) else $error("reserved bits set");
    a_unmapped_zero: assert property (ind_ack && $past(ind_req.rd)
        && !($past(ind_req.addr) inside {[7'h04:7'h0F]}) |-> ind_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_align_width: assert property (ind_ack && $past(ind_req.rd)
        && $past(ind_req.addr) == 7'h04 |-> ind_rdata[7:3] == 5'h00) else $error("04 too wide");
    a_loss_width: assert property (ind_ack && $past(ind_req.rd)
        && $past(ind_req.addr) == 7'h05 |-> ind_rdata[7:5] == 3'h0) else $error("05 too wide");
endmodule // perf_monitor_checker
bind performance_monitor perf_monitor_checker #(
    .SNAPSHOT_PERIOD_CYCLES(SNAPSHOT_PERIOD_CYCLES)) u_chk (.clk(clk), .srst(srst),
    .events(events), .hdb3_select(hdb3_select), .snapshot_trigger(snapshot_trigger),
    .auto_snapshot_enable(auto_snapshot_enable), .ind_req(ind_req), .ind_rdata(ind_rdata),
    .ind_ack(ind_ack), .snapshot_taken(snapshot_taken));

// >>> verif/host_model.sv
// Purpose: microprocessor side of the indirect port
// Assumes: device answers one cycle after a strobe
// Notes: drives on falling edges only
`timescale 1ns/1ps
module host_model (
    input  wire logic                      clk,              // clock
    output perf_monitor_pkg::ind_req_t     ind_req,          // request
    input  wire logic [7:0]                ind_rdata,        // read data
    input  wire logic                      ind_ack,          // access done
    output logic                           snapshot_trigger  // refresh trigger
);
    initial begin
        ind_req = '0;
        snapshot_trigger = 1'b0;
    end
    task automatic access(input logic r, input logic [6:0] a, input logic [7:0] w,
                          output logic [7:0] d, output logic k);
        @(negedge clk);
        ind_req = '{addr: a, rd: r, wr: !r, wdata: w};
        @(negedge clk);
        d = ind_rdata;
        k = ind_ack;
        // released lines show no stale value
        ind_req = '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~w};
    endtask
    task automatic snap();
        @(negedge clk) snapshot_trigger = 1'b1;
        @(negedge clk) snapshot_trigger = 1'b0;
    endtask
endmodule // host_model

// >>> verif/tb.sv
// Purpose: self-checking bench of the counter map
// Assumes: short auto refresh period of 20 cycles
// Notes: counts saturate and restart at each refresh
`timescale 1ns/1ps
`include "perf_monitor_defs.svh"
module tb;
    logic clk = 0, srst = 1, hdb3 = 0, auto_en = 0, ack, trig, taken, k;
    logic [7:0] rdata, d;
    perf_monitor_pkg::event_pulses_t ev = '0;
    perf_monitor_pkg::ind_req_t req;
    int err_total = 0, n_tests = 0, c;
    logic [7:0] exp_map [12] = '{8'h07, 8'h06, 8'h2C, 8'h01, 8'h05, 8'h00,
                                 8'h01, 8'h10, 8'h02, 8'h10, 8'h03, 8'h20};
    initial forever #2.5 clk = ~clk;
    performance_monitor #(.SNAPSHOT_PERIOD_CYCLES(20)) i_dut (.clk(clk), .srst(srst),
        .events(ev), .hdb3_select(hdb3), .snapshot_trigger(trig),
        .auto_snapshot_enable(auto_en), .ind_req(req), .ind_rdata(rdata), .ind_ack(ack),
        .snapshot_taken(taken));
    host_model i_host (.clk(clk), .ind_req(req), .ind_rdata(rdata), .ind_ack(ack),
        .snapshot_trigger(trig));
    task automatic check(string what, logic [7:0] e, logic [7:0] s);
        n_tests++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic rd_chk(logic [6:0] a, logic [7:0] e);
        i_host.access(1'b1, a, 8'h00, d, k);
        check("ack", 8'h01, {7'h00, k});
        check($sformatf("offset %h", a), e, d);
    endtask
    // order: align, oof, pattern, bipolar, code, crc, far, national far
    task automatic run_events(int n [8]);
        int m = 0;
        foreach (n[b]) if (n[b] > m) m = n[b];
        for (int i = 0; i < m; i++) begin
            @(negedge clk);
            for (int b = 0; b < 8; b++) ev[7-b] = (i < n[b]);
        end
        @(negedge clk) ev = '0;
    endtask
    task automatic wait_taken();
        c = 0;
        while (taken !== 1'b1 && c < 100) begin
            @(negedge clk);
            c++;
        end
        // a refresh that never comes is a mismatch
        if (taken !== 1'b1) begin
            err_total++;
            $display("Error snapshot_taken expected 1 seen %b", taken);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        srst = 0;
        for (int a = 4; a < 16; a++) rd_chk(7'(a), 8'h00);
        run_events('{9, 6, 300, 5, 2, 257, 258, 515});
        rd_chk(`PATTERN_ERROR_LOW_OFS, 8'h00);
        i_host.snap();
        i_host.access(1'b0, `PATTERN_ERROR_LOW_OFS, 8'hFF, d, k);
        check("write ack", 8'h01, {7'h00, k});
        for (int a = 4; a < 16; a++) rd_chk(7'(a), exp_map[a-4]);
        rd_chk(7'h03, 8'h00);
        rd_chk(7'h10, 8'h00);
        hdb3 = 1;
        run_events('{0, 0, 0, 4, 3, 0, 0, 0});
        i_host.snap();
        rd_chk(`LINE_VIOLATION_LOW_OFS, 8'h03);
        rd_chk(`PATTERN_ERROR_LOW_OFS, 8'h00);
        run_events('{0, 2, 0, 0, 0, 0, 0, 0});
        auto_en = 1;
        wait_taken();
        check("first tick", 8'h14, 8'(c));
        rd_chk(`OUT_OF_FRAME_OFS, 8'h02);
        wait_taken();
        @(negedge clk);
        wait_taken();
        check("auto period", 8'h13, 8'(c));
        complete_run();
    end
    initial begin
        #50us;
        err_total++;
        complete_run();
    end
endmodule // tb
